// *** logic/acu_core.sv ***
// aes block cipher unit: byte-port buffers, iterative 128-bit engine
`timescale 1ns/10ps
module acu_core #(
  parameter int ADDR_W = 9
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic trx_sleep,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic busy,
  output logic irq
);
  import acu_pkg::*;

  if (ADDR_W < 9) begin : g_chk
    $error("acu_core: ADDR_W must be at least 9");
  end

  //////////////////////////////////////////////////////////////////////
  // galois field and round functions
  function automatic logic [7:0] xt(input logic [7:0] a);
    xt = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] r;
    p = a;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) r = r ^ p;
      p = xt(p);
    end
    gmul = r;
  endfunction

  // a^254 is the field inverse, zero maps to zero
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] p;
    logic [7:0] r;
    p = a;
    r = 8'h01;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    ginv = r;
  endfunction

  function automatic logic [7:0] rl(input logic [7:0] a, input int n);
    rl = 8'((a << n) | (a >> (8 - n)));
  endfunction

  // computed s-box avoids a table that could carry a typo
  function automatic logic [7:0] sb(input logic [7:0] a,
                                    input logic inv);
    logic [7:0] b;
    b = 8'h00;
    if (inv) begin
      b = rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05;
      sb = ginv(b);
    end else begin
      b = ginv(a);
      sb = b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
    end
  endfunction

  // byte i of the state sits at bits 127-8i, column major order
  function automatic logic [127:0] subshift(input logic [127:0] s,
                                            input logic inv);
    logic [127:0] o;
    int src;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? (((c + 4 - r) % 4) * 4 + r) : (((c + r) % 4) * 4 + r);
        o[127-8*(c*4+r) -: 8] = sb(s[127-8*src -: 8], inv);
      end
    end
    subshift = o;
  endfunction

  function automatic logic [127:0] mix(input logic [127:0] s,
                                       input logic inv);
    logic [127:0] o;
    logic [7:0] m [4];
    logic [7:0] acc;
    o = '0;
    acc = 8'h00;
    m[0] = inv ? 8'h0E : 8'h02;
    m[1] = inv ? 8'h0B : 8'h03;
    m[2] = inv ? 8'h0D : 8'h01;
    m[3] = inv ? 8'h09 : 8'h01;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        acc = 8'h00;
        for (int j = 0; j < 4; j++)
          acc = acc ^ gmul(s[127-8*(c*4+j) -: 8], m[(j + 4 - r) % 4]);
        o[127-8*(c*4+r) -: 8] = acc;
      end
    end
    mix = o;
  endfunction

  function automatic logic [7:0] rcon(input logic [3:0] r);
    logic [7:0] v;
    v = 8'h01;
    for (int i = 1; i < NUM_ROUNDS; i++)
      if (i < int'(r)) v = xt(v);
    rcon = v;
  endfunction

  function automatic logic [31:0] subrot(input logic [31:0] w,
                                         input logic [3:0] r);
    subrot = {sb(w[23:16], 1'b0) ^ rcon(r), sb(w[15:8], 1'b0),
              sb(w[7:0], 1'b0), sb(w[31:24], 1'b0)};
  endfunction

  // forward step K(r-1) -> K(r), or backward K(r) -> K(r-1)
  function automatic logic [127:0] keystep(input logic [127:0] k,
                                           input logic [3:0] r,
                                           input logic inv);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    {w0, w1, w2, w3} = k;
    if (inv) begin
      w3 = w3 ^ w2;
      w2 = w2 ^ w1;
      w1 = w1 ^ w0;
      w0 = w0 ^ subrot(w3, r);
    end else begin
      w0 = w0 ^ subrot(w3, r);
      w1 = w1 ^ w0;
      w2 = w2 ^ w1;
      w3 = w3 ^ w2;
    end
    keystep = {w0, w1, w2, w3};
  endfunction

  //////////////////////////////////////////////////////////////////////
  // registers
  acu_state_t state_r;
  logic [7:0] ctrl_r;
  logic done_r;
  logic err_r;
  logic [1:0] evt_r;
  logic [1:0] mask_r;
  logic [127:0] text_r;
  logic [127:0] key_r;
  logic [127:0] rkey_r;
  logic [127:0] st_r;
  logic [127:0] chain_r;
  logic [127:0] cin_r;
  logic [3:0] rnd_r;
  logic [3:0] tptr_r;
  logic [3:0] kptr_r;
  logic [4:0] twr_r;
  logic [4:0] trd_r;
  logic [4:0] kwr_r;
  logic res_pend_r;
  logic [7:0] rdata_r;

  //////////////////////////////////////////////////////////////////////
  // decode
  wire hit_ctrl = addr == ADDR_W'(CTRL_OFS);
  wire hit_stat = addr == ADDR_W'(STAT_OFS);
  wire hit_text = addr == ADDR_W'(TEXT_OFS);
  wire hit_key = addr == ADDR_W'(KEY_OFS);
  wire hit_ist = addr == ADDR_W'(IRQ_STAT_OFS);
  wire hit_imk = addr == ADDR_W'(IRQ_MASK_OFS);
  wire running = state_r == ACU_RUN;
  wire ctrl_acc = hit_ctrl && (wr_stb || rd_stb);
  // a read counts as an access too, so polling control kills a run
  wire abort = running && ctrl_acc;
  wire start_req = !running && hit_ctrl && wr_stb
                   && wdata[CTRL_START_BIT];
  // buffers must be full and a previous result fully read back
  // the key count survives a run because the written key is reused
  wire bufs_ok = kwr_r == 5'(BUF_BYTES) && twr_r == 5'(BUF_BYTES)
                 && (!res_pend_r || trd_r >= 5'(BUF_BYTES));
  wire launch = start_req && bufs_ok;
  wire start_err = start_req && !bufs_ok;
  wire cbc = ctrl_r[CTRL_MODE_BIT];
  wire dec = ctrl_r[CTRL_DIR_BIT];
  wire mode_cbc = wdata[CTRL_MODE_BIT];
  wire mode_dec = wdata[CTRL_DIR_BIT];
  wire last = rnd_r == 4'(NUM_ROUNDS);
  wire text_wr = hit_text && wr_stb && !running;
  wire text_rd = hit_text && rd_stb && !running;
  wire key_wr = hit_key && wr_stb && !running;
  wire key_rd = hit_key && rd_stb && !running;

  // datapath of one round
  wire [127:0] in_blk = (!mode_dec && mode_cbc) ? (text_r ^ chain_r)
                                                : text_r;
  // decryption walks the key schedule back from the last round key
  wire [127:0] rk_nxt = keystep(rkey_r,
                          dec ? 4'(NUM_ROUNDS + 1) - rnd_r : rnd_r, dec);
  wire [127:0] enc_sh = subshift(st_r, 1'b0);
  wire [127:0] enc_nxt = (last ? enc_sh : mix(enc_sh, 1'b0)) ^ rk_nxt;
  wire [127:0] dec_ak = subshift(st_r, 1'b1) ^ rk_nxt;
  wire [127:0] dec_nxt = last ? dec_ak : mix(dec_ak, 1'b1);
  wire [127:0] rnd_out = dec ? dec_nxt : enc_nxt;
  wire [127:0] result = (dec && cbc) ? (rnd_out ^ chain_r) : rnd_out;
  // an abort in the final round wins over completion
  wire finish = running && last && !abort;

  // read mux
  wire [7:0] stat_val = {err_r, 6'h00, done_r};
  wire [7:0] ctrl_val = (ctrl_r & CTRL_RW_MASK)
                        & ~(8'h01 << CTRL_START_BIT);
  wire [7:0] rd_mux = hit_ctrl ? ctrl_val :
                      hit_stat ? stat_val :
                      hit_text ? text_r[127-8*tptr_r -: 8] :
                      hit_key ? rkey_r[127-8*kptr_r -: 8] :
                      hit_ist ? {6'h00, evt_r} :
                      hit_imk ? {6'h00, mask_r} : 8'h00;
  wire [1:0] evt_set = {abort | start_err, finish};
  wire [1:0] evt_clr = (hit_ist && wr_stb) ? wdata[1:0] : 2'h0;

  //////////////////////////////////////////////////////////////////////
  // control, status and interrupt registers
  always_ff @(posedge clock) begin
    if (!rst_n || trx_sleep) begin
      state_r <= ACU_IDLE;
      ctrl_r <= REG_RESET;
      done_r <= 1'b0;
      err_r <= 1'b0;
      rnd_r <= 4'h0;
    end else begin
      if (hit_ctrl && wr_stb)
        ctrl_r <= wdata & CTRL_RW_MASK;
      if (launch) begin
        state_r <= ACU_RUN;
        rnd_r <= 4'h1;
        done_r <= 1'b0;
        err_r <= 1'b0;
      end else if (abort || finish) begin
        state_r <= ACU_IDLE;
      end else if (running) begin
        rnd_r <= rnd_r + 4'h1;
      end
      if (abort || start_err)
        err_r <= 1'b1;
      if (finish)
        done_r <= 1'b1;
    end
  end

  // sticky events: a set in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evt_r <= EVT_RESET;
      mask_r <= EVT_RESET;
    end else begin
      evt_r <= (evt_r & ~evt_clr) | evt_set;
      if (hit_imk && wr_stb)
        mask_r <= wdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // engine state and chaining block
  // an abort freezes the engine, so key readback then shows a partial key
  // the chaining block is shared by both directions; sleep zeroes it
  always_ff @(posedge clock) begin
    if (!rst_n || trx_sleep) begin
      st_r <= '0;
      rkey_r <= '0;
      chain_r <= '0;
      cin_r <= '0;
    end else if (launch) begin
      st_r <= in_blk ^ key_r;
      rkey_r <= key_r;
      cin_r <= text_r;
    end else if (running && !abort) begin
      st_r <= rnd_out;
      rkey_r <= rk_nxt;
      if (last)
        chain_r <= (dec && cbc) ? cin_r : rnd_out;
    end else if (key_wr) begin
      rkey_r[127-8*kptr_r -: 8] <= wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // text buffer behind one byte address
  // a finished run clears the write count, so old text cannot be rerun
  always_ff @(posedge clock) begin
    if (!rst_n || trx_sleep) begin
      text_r <= '0;
      tptr_r <= 4'h0;
      twr_r <= 5'h00;
      trd_r <= 5'h00;
      res_pend_r <= 1'b0;
    end else if (finish) begin
      text_r <= result;
      tptr_r <= 4'h0;
      twr_r <= 5'h00;
      trd_r <= 5'h00;
      res_pend_r <= 1'b1;
    end else if (launch) begin
      tptr_r <= 4'h0;
    end else if (text_wr) begin
      text_r[127-8*tptr_r -: 8] <= wdata;
      tptr_r <= tptr_r + 4'h1;
      if (twr_r != 5'(BUF_BYTES))
        twr_r <= twr_r + 5'h01;
    end else if (text_rd) begin
      tptr_r <= tptr_r + 4'h1;
      if (trd_r != 5'(BUF_BYTES))
        trd_r <= trd_r + 5'h01;
    end
  end

  // original key buffer, untouched by a run
  always_ff @(posedge clock) begin
    if (!rst_n || trx_sleep) begin
      key_r <= '0;
      kptr_r <= 4'h0;
      kwr_r <= 5'h00;
    end else if (key_wr) begin
      key_r[127-8*kptr_r -: 8] <= wdata;
      kptr_r <= kptr_r + 4'h1;
      if (kwr_r != 5'(BUF_BYTES))
        kwr_r <= kwr_r + 5'h01;
    end else if (key_rd) begin
      kptr_r <= kptr_r + 4'h1;
    end
  end

  // read data stands in the cycle after the strobe
  // zero between reads makes a missed strobe easy to spot
  always_ff @(posedge clock) begin
    if (!rst_n)
      rdata_r <= 8'h00;
    else
      rdata_r <= rd_stb ? rd_mux : 8'h00;
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata = rdata_r;
  assign busy = running;
  // interrupt only while the enable bit in control is set
  assign irq = ctrl_r[CTRL_IRQ_EN_BIT] && |(evt_r & mask_r);
endmodule

// *** pkg/acu_pkg.sv ***
// constants for the aes block cipher unit
package acu_pkg;
  localparam logic [8:0] CTRL_OFS = 9'h13C;
  localparam logic [8:0] STAT_OFS = 9'h13D;
  localparam logic [8:0] TEXT_OFS = 9'h13E;
  localparam logic [8:0] KEY_OFS = 9'h13F;
  localparam logic [8:0] IRQ_STAT_OFS = 9'h138;
  localparam logic [8:0] IRQ_MASK_OFS = 9'h139;
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_MODE_BIT = 5;
  localparam int CTRL_DIR_BIT = 3;
  localparam int CTRL_IRQ_EN_BIT = 2;
  localparam int STAT_ERR_BIT = 7;
  localparam int STAT_DONE_BIT = 0;
  localparam int EVT_DONE_BIT = 0;
  localparam int EVT_ERR_BIT = 1;
  localparam logic [7:0] CTRL_RW_MASK = 8'hAC;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] EVT_RESET = 2'h0;
  localparam int BUF_BYTES = 16;
  localparam int NUM_ROUNDS = 10;
  typedef enum logic [1:0] {
    ACU_IDLE = 2'b01,
    ACU_RUN = 2'b10
  } acu_state_t;
endpackage

// *** tb/acu_core_checker.sv ***
// port-level assertions for the cipher unit
`timescale 1ns/10ps
module acu_checker
  import acu_pkg::*;
#(
  parameter int ADDR_W = 9
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic trx_sleep,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic busy,
  input wire logic irq
);
  // control decode; any access, read too, counts as touching control
  wire ctl_hit = addr == ADDR_W'(CTRL_OFS);
  wire ctl_acc = ctl_hit && (wr_stb || rd_stb);
  wire start_req = wr_stb && ctl_hit && wdata[CTRL_START_BIT];
  wire off_map = addr < ADDR_W'(IRQ_STAT_OFS) || addr > ADDR_W'(KEY_OFS);
  wire stat_rd = rd_stb && addr == ADDR_W'(STAT_OFS);
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // reset and decode
  a_reset_quiet: assert property ($rose(rst_n) |-> !busy && !irq && !rdata)
    else $error("outputs not quiet after reset");
  a_unmapped_zero: assert property (rd_stb && off_map |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  // launch and run length
  a_start_cause: assert property ($rose(busy) |-> $past(start_req))
    else $error("run began without start write");
  a_run_bounded: assert property ($rose(busy) |-> ##[1:10] !busy)
    else $error("run longer than ten rounds");
  a_no_start: assert property (!busy && ctl_acc && !start_req |=> !busy)
    else $error("run began without start bit");
  a_abort_stop: assert property (busy && ctl_acc |=> !busy)
    else $error("control access did not abort");
  // sleep entry
  a_sleep_idle: assert property (trx_sleep |=> !busy)
    else $error("busy after sleep");
  a_sleep_stat: assert property (trx_sleep ##1 stat_rd |=> !rdata)
    else $error("status not cleared by sleep");
  // interrupt
  a_irq_cause: assert property ($rose(irq) |-> $past(busy) || $past(wr_stb))
    else $error("interrupt rose without cause");
  a_irq_disable: assert property (!busy && wr_stb && ctl_hit &&
    !wdata[CTRL_IRQ_EN_BIT] |=> !irq) else $error("irq while disabled");
endmodule
bind acu_core acu_checker #(.ADDR_W(ADDR_W)) acu_checker_i (
  .clock(clock), .rst_n(rst_n), .trx_sleep(trx_sleep), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .busy(busy), .irq(irq));

// *** tb/test_aes_block_cipher_unit.sv ***
// self-checking bench for the cipher unit register port
`timescale 1ns/10ps
module test_aes_block_cipher_unit;
  import acu_pkg::*;
  localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] RK = 128'h13111D7FE3944A17F307A78B4D2B30C5;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic trx_sleep = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic busy;
  logic irq;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  //////////////////////////////////////////////////////////////////
  // 100 ns period
  always #50 clock = ~clock;
  acu_core acu_core_i (.clock(clock), .rst_n(rst_n), .trx_sleep(trx_sleep),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .busy(busy), .irq(irq));
  // verdict
  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // bus cycles; each leaves one idle cycle so strobes never double up
  task automatic wr(logic [8:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic chk(logic [8:0] a, logic [7:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    tests_run++;
    if (rdata !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, rdata, e);
    end
    @(posedge clock);
  endtask
  task automatic cbit(logic g, logic e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // byte 0 of a block travels first
  task automatic wbuf(logic [8:0] a, logic [127:0] d);
    for (int i = 15; i >= 0; i--) wr(a, d[i*8 +: 8]);
  endtask
  task automatic cbuf(logic [8:0] a, logic [127:0] e);
    for (int i = 15; i >= 0; i--) chk(a, e[i*8 +: 8]);
  endtask
  // ten rounds end ten cycles after launch
  task automatic run(logic [7:0] c);
    wr(CTRL_OFS, c);
    repeat (12) @(posedge clock);
  endtask
  // cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk(CTRL_OFS, REG_RESET);
    chk(STAT_OFS, REG_RESET);
    chk(IRQ_STAT_OFS, 8'h00);
    chk(9'h100, 8'h00);
    wr(CTRL_OFS, 8'h2C);
    chk(CTRL_OFS, 8'h2C);
    run(8'h80);
    chk(STAT_OFS, 8'h80);
    wr(IRQ_MASK_OFS, 8'h01);
    wbuf(KEY_OFS, KEY);
    wbuf(TEXT_OFS, PT);
    run(8'h84);
    chk(STAT_OFS, 8'h01);
    cbit(irq, 1'b1);
    cbuf(TEXT_OFS, CT);
    cbuf(KEY_OFS, RK);
    wr(IRQ_MASK_OFS, 8'h00);
    cbit(irq, 1'b0);
    wr(IRQ_MASK_OFS, 8'h01);
    wr(IRQ_STAT_OFS, 8'h01);
    cbit(irq, 1'b0);
    wbuf(TEXT_OFS, PT);
    run(8'h80);
    cbit(irq, 1'b0);
    cbuf(TEXT_OFS, CT);
    wr(CTRL_OFS, 8'h04);
    cbit(irq, 1'b1);
    wr(IRQ_STAT_OFS, 8'h03);
    // cbc: the chain holds the last ciphertext, so the xor cancels
    wbuf(TEXT_OFS, PT ^ CT);
    run(8'hA0);
    chk(STAT_OFS, 8'h01);
    cbuf(TEXT_OFS, CT);
    wbuf(KEY_OFS, RK);
    wbuf(TEXT_OFS, CT);
    run(8'hA8);
    cbuf(TEXT_OFS, PT ^ CT);
    wbuf(TEXT_OFS, CT);
    run(8'h88);
    cbuf(TEXT_OFS, PT);
    cbuf(KEY_OFS, KEY);
    wbuf(TEXT_OFS, PT);
    run(8'h80);
    wbuf(TEXT_OFS, PT);
    run(8'h80);
    chk(STAT_OFS, 8'h81);
    wr(CTRL_OFS, 8'h2C);
    trx_sleep <= 1'b1;
    @(posedge clock);
    trx_sleep <= 1'b0;
    chk(STAT_OFS, 8'h00);
    chk(CTRL_OFS, 8'h00);
    cbuf(KEY_OFS, 128'h0);
    wbuf(KEY_OFS, KEY);
    wbuf(TEXT_OFS, PT);
    wr(CTRL_OFS, 8'h80);
    cbit(busy, 1'b1);
    wr(CTRL_OFS, 8'h00);
    cbit(busy, 1'b0);
    chk(STAT_OFS, 8'h80);
    // a control read while running aborts as a write does
    wr(CTRL_OFS, 8'h80);
    cbit(busy, 1'b1);
    chk(CTRL_OFS, 8'h00);
    cbit(busy, 1'b0);
    chk(STAT_OFS, 8'h80);
    tally_and_finish();
  end
endmodule
